// File: rtl/ssp_pkg.sv
/*
  Constants for the synchronous serial port in its SPI mode: control and
  status bit positions, reset values, mode codes and clock dividers.
  Assumes the system clock runs at 125 MHz and stands in for the oscillator.
*/
// Notes on behaviour
// - Each transfer moves one byte both ways
// - Control and status bits select the mode
// - Shift register moves MSB first both ways
// - Full byte copies to buffer, sets flags
// - Refused buffer write sets sticky collision flag
// - Reading the buffer clears the full flag
// - Shift register reached only through the buffer
// - Enable bit hands pins to the port
// - Software disables, rewrites, re-enables to reconfigure
// - Software sets pin directions per role
// - Master transfer starts on buffer write
// - Data-out disabled master still receives bytes
// - Polarity bit sets the clock idle level
// - Master rate: divide 4, 16, 64, timer/2
// - Edge bit set: data valid before first edge
// - Sample phase: middle or end of bit
// - Shift on own edge, latch on opposite
// - Slave shifts on external clock, flags last bit
// - Slave works asleep; received byte wakes device
// - Select mode: low enables, high floats data-out
// - Select high or disable clears bit counter
// - Slave with edge bit set uses select (not enforced: MODE_S_NOSEL runs without it)
// - Sleep freezes master transfer, resumes after
// - Any reset disables port, aborts transfer
package ssp_pkg;
  localparam int BITS = 8;
  localparam int CTL_WRITE_COLLISION_FLAG = 7;
  localparam int CTL_EN = 5;
  localparam int CTL_CKP = 4;
  localparam int STAT_SMP = 7;
  localparam int STAT_CKE = 6;
  localparam int STAT_BF = 0;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [3:0] MODE_M_DIV4 = 4'h0;
  localparam logic [3:0] MODE_M_DIV16 = 4'h1;
  localparam logic [3:0] MODE_M_DIV64 = 4'h2;
  localparam logic [3:0] MODE_M_TMR = 4'h3;
  localparam logic [3:0] MODE_S_SEL = 4'h4;
  localparam logic [3:0] MODE_S_NOSEL = 4'h5;
  localparam int DIV4 = 4;
  localparam int DIV16 = 16;
  localparam int DIV64 = 64;
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] LIM4 = DIV_W'(DIV4 / 2 - 1);
  localparam logic [DIV_W-1:0] LIM16 = DIV_W'(DIV16 / 2 - 1);
  localparam logic [DIV_W-1:0] LIM64 = DIV_W'(DIV64 / 2 - 1);
  typedef enum logic [1:0] {SSP_IDLE = 2'b01, SSP_RUN = 2'b10} ssp_state_t;
endpackage

// File: rtl/ssp_if.sv
/*
  Serial link between the port and its partner: clock, two data lines and
  select. Resolves each shared wire from the drivers' enables; undriven
  data lines float high, an undriven clock reads low.
*/
`timescale 1ns/1ps
interface ssp_if;
  logic dev_sck_o;
  logic dev_sck_oe;
  logic dev_sdo;
  logic dev_sdo_oe;
  logic peer_sck_o;
  logic peer_sck_oe;
  logic peer_sdo;
  logic peer_sdo_oe;
  logic peer_ss_n;
  logic sck;
  logic dev_sdi;
  logic peer_sdi;

  // Wire levels from the enables
  assign sck = dev_sck_oe ? dev_sck_o : (peer_sck_oe ? peer_sck_o : 1'b0);
  assign dev_sdi = peer_sdo_oe ? peer_sdo : 1'b1;
  assign peer_sdi = dev_sdo_oe ? dev_sdo : 1'b1;

  modport dev (output dev_sck_o, dev_sck_oe, dev_sdo, dev_sdo_oe,
               input sck, dev_sdi, peer_ss_n);
  modport peer (output peer_sck_o, peer_sck_oe, peer_sdo, peer_sdo_oe, peer_ss_n,
                input sck, peer_sdi);
endinterface

// File: rtl/ssp_dev.sv
/*
  Synchronous serial port, SPI mode: one shift register, a receive buffer,
  master clock generation and slave operation with optional select.
  Assumes all link and user inputs are synchronous to clock.
*/
`timescale 1ns/1ps
module ssp_dev (
  input  wire logic       clock,
  input  wire logic       resetn,
  ssp_if.dev              lnk,
  input  wire logic       ctl_wr,
  input  wire logic [7:0] ctl_wdata,
  input  wire logic       stat_wr,
  input  wire logic [7:0] stat_wdata,
  input  wire logic       buf_wr,
  input  wire logic [7:0] buf_wdata,
  input  wire logic       buf_rd,
  input  wire logic       irq_clr,
  input  wire logic       sleep,
  input  wire logic       aux_tick,
  input  wire logic       sdo_dir_out,
  output logic      [7:0] ctl_q,
  output logic      [7:0] stat_q,
  output logic      [7:0] buf_q,
  output logic            irq_flag,
  output logic            wake
);
  import ssp_pkg::*;

  ssp_state_t       st_reg, st_next;
  logic [5:0]       ctl_reg, ctl_next;
  logic             write_collision_flag_reg, write_collision_flag_next;
  logic             smp_reg, smp_next;
  logic             cke_reg, cke_next;
  logic             bf_reg, bf_next;
  logic             irq_reg, irq_next;
  logic             wake_reg, wake_next;
  logic [7:0]       buf_reg, buf_next;
  logic [7:0]       sr_reg, sr_next;
  logic [2:0]       cnt_reg, cnt_next;
  logic             ph_reg, ph_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic             samp_reg, samp_next;
  logic             sck_reg, sck_next;
  logic             sckoe_reg, sckoe_next;
  logic             sdo_reg, sdo_next;
  logic             sdooe_reg, sdooe_next;
  logic             sckq_reg, sckq_next;
  logic             sckp_reg, sckp_next;

  logic             en;
  logic [3:0]       mode;
  logic             master;
  logic             sreset;
  logic             tick;
  logic             busy;
  logic             bit_in;
  logic             edge_seen;
  logic             act;
  logic [DIV_W-1:0] lim;
  logic [7:0]       shifted;

  ////////////////////////////////////////////////////////////////////////
  // Decode of the control bits
  assign en = ctl_reg[CTL_EN];
  assign mode = ctl_reg[3:0];
  assign master = (mode < MODE_S_SEL);
  assign sreset = !en || (mode == MODE_S_SEL && lnk.peer_ss_n);
  assign busy = master ? (st_reg == SSP_RUN) : (cnt_reg != 3'h0);

  // Half-period tick of the master clock
  always_comb
  begin
    unique case (mode)
      MODE_M_DIV16: lim = LIM16;
      MODE_M_DIV64: lim = LIM64;
      default:      lim = LIM4;
    endcase
  end
  // Timer pulses count only once a clock has passed since the last toggle
  assign tick = (mode == MODE_M_TMR) ? (aux_tick && div_reg != '0) : (div_reg == lim);

  // Slave clock edges seen against the idle level
  assign edge_seen = sckq_reg ^ sckp_reg;
  assign act = sckq_reg ^ ctl_reg[CTL_CKP];

  ////////////////////////////////////////////////////////////////////////
  // Next state of the whole port
  always_comb
  begin
    st_next = st_reg;
    ctl_next = ctl_reg;
    write_collision_flag_next = write_collision_flag_reg;
    smp_next = smp_reg;
    cke_next = cke_reg;
    bf_next = bf_reg;
    irq_next = irq_reg;
    wake_next = 1'b0;
    buf_next = buf_reg;
    sr_next = sr_reg;
    cnt_next = cnt_reg;
    ph_next = ph_reg;
    div_next = div_reg;
    samp_next = samp_reg;
    sdo_next = sdo_reg;
    sckq_next = lnk.sck;
    sckp_next = sckq_reg;
    bit_in = samp_reg;
    shifted = {sr_reg[6:0], samp_reg};
    // Software register writes and clears of sticky flags
    if (ctl_wr)
    begin
      ctl_next = ctl_wdata[5:0];
      write_collision_flag_next = write_collision_flag_reg & ctl_wdata[CTL_WRITE_COLLISION_FLAG];
    end
    if (stat_wr)
    begin
      smp_next = stat_wdata[STAT_SMP];
      cke_next = stat_wdata[STAT_CKE];
    end
    if (buf_rd)
      bf_next = 1'b0;
    if (irq_clr)
      irq_next = 1'b0;
    // Buffer write: start, load or collide
    if (buf_wr)
    begin
      if (busy && !sreset)
        write_collision_flag_next = 1'b1;
      else
      begin
        buf_next = buf_wdata;
        sr_next = buf_wdata;
        sdo_next = buf_wdata[7];
        if (master && en)
        begin
          st_next = SSP_RUN;
          ph_next = 1'b0;
          div_next = '0;
          cnt_next = 3'h0;
        end
      end
    end
    if (sreset)
    begin
      st_next = SSP_IDLE;
      cnt_next = 3'h0;
      ph_next = 1'b0;
      div_next = '0;
    end
    else if (master)
    begin
      if (st_reg == SSP_RUN && !sleep)
      begin
        if (tick)
        begin
          div_next = '0;
          ph_next = ~ph_reg;
          if (!ph_reg && !smp_reg)
            samp_next = lnk.dev_sdi;
          if (ph_reg)
          begin
            bit_in = smp_reg ? lnk.dev_sdi : samp_reg;
            shifted = {sr_reg[6:0], bit_in};
            sr_next = shifted;
            sdo_next = sr_reg[6];
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'(BITS - 1))
            begin
              st_next = SSP_IDLE;
              buf_next = shifted;
              bf_next = 1'b1;
              irq_next = 1'b1;
            end
          end
        end
        else if (div_reg != lim)
          div_next = div_reg + DIV_W'(1); // Holds at limit in timer mode
      end
    end
    else
    begin
      if (edge_seen && (act == cke_reg))
      begin
        shifted = {sr_reg[6:0], lnk.dev_sdi};
        sr_next = shifted;
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == 3'(BITS - 1))
        begin
          buf_next = shifted;
          bf_next = 1'b1;
          irq_next = 1'b1;
          wake_next = sleep;
        end
      end
      if (edge_seen && (act != cke_reg))
        sdo_next = sr_reg[7];
    end
  end

  // Pin drive follows enable, role and select
  assign sckoe_next = en && master;
  assign sck_next = ctl_reg[CTL_CKP] ^ ((st_next == SSP_RUN) && (ph_next == cke_reg));
  assign sdooe_next = en && sdo_dir_out &&
                      (master || mode == MODE_S_NOSEL ||
                       (mode == MODE_S_SEL && !lnk.peer_ss_n));

  ////////////////////////////////////////////////////////////////////////
  // Registers; reset disables the port
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= SSP_IDLE;
      ctl_reg <= CTL_RST[5:0];
      write_collision_flag_reg <= CTL_RST[CTL_WRITE_COLLISION_FLAG];
      smp_reg <= STAT_RST[STAT_SMP];
      cke_reg <= STAT_RST[STAT_CKE];
      bf_reg <= STAT_RST[STAT_BF];
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      buf_reg <= 8'h00;
      sr_reg <= 8'h00;
      cnt_reg <= 3'h0;
      ph_reg <= 1'b0;
      div_reg <= '0;
      samp_reg <= 1'b0;
      sck_reg <= 1'b0;
      sckoe_reg <= 1'b0;
      sdo_reg <= 1'b0;
      sdooe_reg <= 1'b0;
      sckq_reg <= 1'b0;
      sckp_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      ctl_reg <= ctl_next;
      write_collision_flag_reg <= write_collision_flag_next;
      smp_reg <= smp_next;
      cke_reg <= cke_next;
      bf_reg <= bf_next;
      irq_reg <= irq_next;
      wake_reg <= wake_next;
      buf_reg <= buf_next;
      sr_reg <= sr_next;
      cnt_reg <= cnt_next;
      ph_reg <= ph_next;
      div_reg <= div_next;
      samp_reg <= samp_next;
      sck_reg <= sck_next;
      sckoe_reg <= sckoe_next;
      sdo_reg <= sdo_next;
      sdooe_reg <= sdooe_next;
      sckq_reg <= sckq_next;
      sckp_reg <= sckp_next;
    end
  end

  // Outputs straight from the registers
  assign lnk.dev_sck_o = sck_reg;
  assign lnk.dev_sck_oe = sckoe_reg;
  assign lnk.dev_sdo = sdo_reg;
  assign lnk.dev_sdo_oe = sdooe_reg;
  assign ctl_q = {write_collision_flag_reg, 1'b0, ctl_reg};
  assign stat_q = {smp_reg, cke_reg, 5'h00, bf_reg};
  assign buf_q = buf_reg;
  assign irq_flag = irq_reg;
  assign wake = wake_reg;
endmodule

// File: rtl/ssp_peer.sv
/*
  Partner end of the serial link: a plain SPI master or slave moving one
  byte per request, MSB first, sampling mid-bit.
  Assumes link and user inputs are synchronous to clock.
*/
`timescale 1ns/1ps
module ssp_peer #(
  parameter int HALF = 2
) (
  input  wire logic       clock,
  input  wire logic       resetn,
  ssp_if.peer             lnk,
  input  wire logic       as_master,
  input  wire logic       clock_idle_polarity,
  input  wire logic       cke,
  input  wire logic       start,
  input  wire logic [7:0] tx_data,
  output logic      [7:0] rx_data,
  output logic            done
);
  import ssp_pkg::*;

  ssp_state_t  st_reg, st_next;
  logic [7:0]  sr_reg, sr_next;
  logic [7:0]  rx_reg, rx_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic        ph_reg, ph_next;
  logic [15:0] div_reg, div_next;
  logic        samp_reg, samp_next;
  logic        done_reg, done_next;
  logic        sck_reg, sck_next;
  logic        sdo_reg, sdo_next;
  logic        ssn_reg, ssn_next;
  logic        sckq_reg, sckq_next;
  logic        sck_edge;
  logic        act;
  logic [7:0]  shifted;

  // Edge seen in the clock the wire moves, level taken from the wire
  assign sck_edge = lnk.sck ^ sckq_reg;
  assign act = lnk.sck ^ clock_idle_polarity;

  ////////////////////////////////////////////////////////////////////////
  // Next state: master drives clock and select, slave follows edges
  always_comb
  begin
    st_next = st_reg;
    sr_next = sr_reg;
    rx_next = rx_reg;
    cnt_next = cnt_reg;
    ph_next = ph_reg;
    div_next = div_reg;
    samp_next = samp_reg;
    done_next = 1'b0;
    sdo_next = sdo_reg;
    sckq_next = lnk.sck;
    shifted = {sr_reg[6:0], samp_reg};
    if (as_master)
    begin
      if (st_reg == SSP_RUN)
      begin
        if (div_reg == 16'(HALF - 1))
        begin
          div_next = 16'h0000;
          ph_next = ~ph_reg;
          if (!ph_reg)
            samp_next = lnk.peer_sdi;
          else
          begin
            sr_next = shifted;
            sdo_next = sr_reg[6];
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'(BITS - 1))
            begin
              st_next = SSP_IDLE;
              rx_next = shifted;
              done_next = 1'b1;
            end
          end
        end
        else
          div_next = div_reg + 16'h0001;
      end
      else if (start)
      begin
        st_next = SSP_RUN;
        sr_next = tx_data;
        sdo_next = tx_data[7];
        ph_next = 1'b0;
        div_next = 16'h0000;
        cnt_next = 3'h0;
      end
    end
    else
    begin
      st_next = SSP_IDLE;
      if (start)
      begin
        sr_next = tx_data; // Start realigns the bit count
        sdo_next = tx_data[7];
        cnt_next = 3'h0;
      end
      else if (sck_edge && (act == cke))
      begin
        shifted = {sr_reg[6:0], lnk.peer_sdi};
        sr_next = shifted;
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == 3'(BITS - 1))
        begin
          rx_next = shifted;
          done_next = 1'b1;
        end
      end
      else if (sck_edge)
        sdo_next = sr_reg[7];
    end
  end

  // Clock idles at the shared polarity; select low while a byte runs
  assign sck_next = clock_idle_polarity ^ ((st_next == SSP_RUN) && (ph_next == cke));
  assign ssn_next = !(as_master && st_next == SSP_RUN);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= SSP_IDLE;
      sr_reg <= 8'h00;
      rx_reg <= 8'h00;
      cnt_reg <= 3'h0;
      ph_reg <= 1'b0;
      div_reg <= 16'h0000;
      samp_reg <= 1'b0;
      done_reg <= 1'b0;
      sck_reg <= 1'b0;
      sdo_reg <= 1'b0;
      ssn_reg <= 1'b1;
      sckq_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      sr_reg <= sr_next;
      rx_reg <= rx_next;
      cnt_reg <= cnt_next;
      ph_reg <= ph_next;
      div_reg <= div_next;
      samp_reg <= samp_next;
      done_reg <= done_next;
      sck_reg <= sck_next;
      sdo_reg <= sdo_next;
      ssn_reg <= ssn_next;
      sckq_reg <= sckq_next;
    end
  end

  assign lnk.peer_sck_o = sck_reg;
  assign lnk.peer_sck_oe = as_master;
  assign lnk.peer_sdo = sdo_reg;
  assign lnk.peer_sdo_oe = 1'b1;
  assign lnk.peer_ss_n = ssn_reg;
  assign rx_data = rx_reg;
  assign done = done_reg;
endmodule

// File: tb/ssp_checker.sv
/*
  Link checker for the port and its partner.
  Assumes one clock, async active-low reset, partner half period of HALF clocks.
*/
`timescale 1ns/1ps
module ssp_checker #(
  parameter int HALF = 2
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic dev_sck_o,
  input wire logic dev_sck_oe,
  input wire logic dev_sdo_oe,
  input wire logic peer_sck_o,
  input wire logic peer_ss_n,
  input wire logic sck
);
  localparam int FMIN = 16 * HALF - 2;
  localparam int FMAX = 16 * HALF + 8;
  logic [5:0] edg_reg;
  logic [5:0] edg_next;
  logic [5:0] edg_now;
  logic [5:0] cyc_reg;
  logic [5:0] cyc_next;
  logic       sck_reg;
  logic       lvl_reg;
  logic       lvl_next;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  // Edge and cycle counts within a select frame
  assign edg_now = edg_reg + 6'(sck != sck_reg);
  always_comb
  begin
    edg_next = peer_ss_n ? 6'h00 : edg_now;
    cyc_next = peer_ss_n ? 6'h00 : cyc_reg + 6'h01;
    lvl_next = peer_ss_n ? sck : lvl_reg;
  end
  // Counter registers
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      edg_reg <= 6'h00;
      cyc_reg <= 6'h00;
      sck_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end
    else
    begin
      edg_reg <= edg_next;
      cyc_reg <= cyc_next;
      sck_reg <= sck;
      lvl_reg <= lvl_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_reset_idle;
    !$past(resetn) |-> !dev_sck_oe && !dev_sdo_oe && peer_ss_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("link driven after reset");
  property p_half_min;
    dev_sck_oe && $past(dev_sck_oe) && $changed(dev_sck_o) |=> $stable(dev_sck_o);
  endproperty
  a_half_min: assert property (p_half_min)
    else $error("master clock half too short");
  property p_peer_half;
    !peer_ss_n && $changed(peer_sck_o) |=> $stable(peer_sck_o);
  endproperty
  a_peer_half: assert property (p_peer_half)
    else $error("partner clock half too short");
  property p_frame_edges;
    $rose(peer_ss_n) |-> edg_now == 6'h10;
  endproperty
  a_frame_edges: assert property (p_frame_edges)
    else $error("frame edge count wrong");
  property p_frame_time;
    $rose(peer_ss_n) |-> cyc_reg >= FMIN && cyc_reg <= FMAX;
  endproperty
  a_frame_time: assert property (p_frame_time)
    else $error("frame length wrong");
  property p_idle_frame;
    $rose(peer_ss_n) |-> sck == lvl_reg;
  endproperty
  a_idle_frame: assert property (p_idle_frame)
    else $error("clock not idle at frame end");
  property p_sdo_float;
    $rose(peer_ss_n) && !dev_sck_oe |-> ##[1:2] !dev_sdo_oe;
  endproperty
  a_sdo_float: assert property (p_sdo_float)
    else $error("data out not floated");
  property p_sdo_select;
    dev_sdo_oe && !dev_sck_oe |-> !peer_ss_n || !$past(peer_ss_n) || !$past(peer_ss_n, 2);
  endproperty
  a_sdo_select: assert property (p_sdo_select)
    else $error("slave drives without select");
  c_frame: cover property ($rose(peer_ss_n));
  c_float: cover property ($fell(dev_sdo_oe) && !dev_sck_oe);
  c_master: cover property ($rose(dev_sck_oe));
endmodule

// File: tb/ssp_bench.sv
/*
  Bench joining the port and its partner over the link.
  Assumes the package constants and a 125 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module ssp_bench;
  import ssp_pkg::*;
  logic       clock, resetn, ctl_wr, stat_wr, buf_wr, buf_rd, irq_clr, sleep;
  logic       aux_tick, sdo_dir_out, irq_flag, wake, as_master, clock_idle_polarity, cke, start;
  logic       done, woke;
  logic [7:0] ctl_wdata, stat_wdata, buf_wdata, ctl_q, stat_q, buf_q, tx_data, rx_data;
  int         num_errors, tests_run;
  ssp_if ssp_if_i ();
  ssp_dev ssp_dev_i (.clock(clock), .resetn(resetn), .lnk(ssp_if_i.dev), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .stat_wr(stat_wr), .stat_wdata(stat_wdata), .buf_wr(buf_wr),
    .buf_wdata(buf_wdata), .buf_rd(buf_rd), .irq_clr(irq_clr), .sleep(sleep),
    .aux_tick(aux_tick), .sdo_dir_out(sdo_dir_out), .ctl_q(ctl_q), .stat_q(stat_q),
    .buf_q(buf_q), .irq_flag(irq_flag), .wake(wake));
  ssp_peer #(.HALF(3)) ssp_peer_i (.clock(clock), .resetn(resetn), .lnk(ssp_if_i.peer),
    .as_master(as_master), .clock_idle_polarity(clock_idle_polarity), .cke(cke), .start(start), .tx_data(tx_data),
    .rx_data(rx_data), .done(done));
  ssp_checker #(.HALF(3)) ssp_checker_i (.clock(clock), .resetn(resetn),
    .dev_sck_o(ssp_if_i.dev_sck_o), .dev_sck_oe(ssp_if_i.dev_sck_oe),
    .dev_sdo_oe(ssp_if_i.dev_sdo_oe), .peer_sck_o(ssp_if_i.peer_sck_o),
    .peer_ss_n(ssp_if_i.peer_ss_n), .sck(ssp_if_i.sck));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, aux timer pulses, wake capture
  always #4 clock = ~clock;
  always @(posedge clock) aux_tick <= #1 ~aux_tick;
  always @(posedge clock) if (wake === 1'b1) woke <= 1'b1;
  task automatic tick(int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic conclude;
    if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr_ctl(logic [7:0] v);
    ctl_wdata = v; ctl_wr = 1'b1; tick(); ctl_wr = 1'b0;
  endtask
  task automatic wr_buf(logic [7:0] v);
    buf_wdata = v; buf_wr = 1'b1; tick(); buf_wr = 1'b0;
  endtask
  // Disable, rewrite, enable; partner set to match
  task automatic cfg(logic [3:0] m, logic p, logic e, logic s);
    wr_ctl(8'h00);
    stat_wdata = {s, e, 6'h00}; stat_wr = 1'b1; tick(); stat_wr = 1'b0;
    clock_idle_polarity = p; cke = e;
    wr_ctl({2'b00, 1'b1, p, m});
    tick();
    `CHK(ssp_if_i.dev_sck_oe, m < 4'h4)
  endtask
  // Wait for a byte, check both ends, then read and clear
  task automatic finish_byte(logic [7:0] dev_exp, logic [7:0] peer_exp);
    int n;
    n = 0;
    while (irq_flag !== 1'b1 && n < 3000) begin tick(); n++; end
    tick(4);
    `CHK(buf_q, dev_exp)
    `CHK(stat_q[STAT_BF], 1'b1)
    `CHK(irq_flag, 1'b1)
    `CHK(rx_data, peer_exp)
    buf_rd = 1'b1; irq_clr = 1'b1; tick(); buf_rd = 1'b0; irq_clr = 1'b0; tick();
    `CHK(stat_q[STAT_BF], 1'b0)
    `CHK(irq_flag, 1'b0)
  endtask
  // Port as master; act 1 collides, act 2 sleeps mid-byte
  task automatic mxfer(logic [7:0] d, logic [7:0] p, logic [7:0] pe, int act);
    logic s;
    tx_data = p; start = 1'b1; tick(); start = 1'b0;
    wr_buf(d);
    if (act == 1) begin tick(4); wr_buf(~d); `CHK(ctl_q[CTL_WRITE_COLLISION_FLAG], 1'b1) end
    if (act == 2)
    begin
      tick(4); sleep = 1'b1; tick(); s = ssp_if_i.sck; tick(20);
      `CHK(ssp_if_i.sck, s)
      `CHK(irq_flag, 1'b0)
      sleep = 1'b0;
    end
    finish_byte(p, pe);
  endtask
  // Port as select-controlled slave
  task automatic sxfer(logic [7:0] d, logic [7:0] p);
    wr_buf(d);
    tx_data = p; start = 1'b1; tick(); start = 1'b0;
    finish_byte(p, d);
    `CHK(ssp_if_i.dev_sdo_oe, 1'b0)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 0; resetn = 0; aux_tick = 0; woke = 0; sleep = 0; sdo_dir_out = 1;
    {ctl_wr, stat_wr, buf_wr, buf_rd, irq_clr, as_master, clock_idle_polarity, cke, start} = '0;
    {ctl_wdata, stat_wdata, buf_wdata, tx_data} = '0;
    num_errors = 0; tests_run = 0;
    tick(12);
    resetn = 1;
    tick();
    `CHK(ctl_q, CTL_RST)
    `CHK(stat_q, STAT_RST)
    for (int i = 0; i < 16; i++)
    begin
      cfg(4'(i % 4), i[2], i[3], i[0]);
      mxfer(8'h81 + 8'(i) * 8'h13, 8'h3c ^ 8'(i), 8'h81 + 8'(i) * 8'h13, 0);
    end
    cfg(MODE_M_DIV16, 1'b0, 1'b0, 1'b0);
    mxfer(8'h3c, 8'h69, 8'h3c, 1);
    `CHK(ctl_q[CTL_WRITE_COLLISION_FLAG], 1'b1)
    wr_ctl(ctl_q & 8'h7f);
    `CHK(ctl_q[CTL_WRITE_COLLISION_FLAG], 1'b0)
    mxfer(8'he1, 8'h1e, 8'he1, 2);
    sdo_dir_out = 0;
    mxfer(8'h5a, 8'h96, 8'hff, 0);
    sdo_dir_out = 1;
    cfg(MODE_S_SEL, 1'b1, 1'b0, 1'b0);
    tick(4);
    as_master = 1;
    tick(4);
    sxfer(8'hc5, 8'h3a);
    sleep = 1;
    sxfer(8'h70, 8'h0e);
    sleep = 0;
    `CHK(woke, 1'b1)
    tx_data = 8'hff; start = 1'b1; tick(); start = 1'b0;
    tick(10);
    wr_ctl(8'h00);
    tick(60);
    `CHK(irq_flag, 1'b0)
    `CHK(stat_q[STAT_BF], 1'b0)
    cfg(MODE_S_SEL, 1'b1, 1'b0, 1'b0);
    sxfer(8'h0f, 8'hb4);
    conclude();
  end
  // Watchdog
  initial
  begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule
